// ==== design/sg_dma_fifo_channel.sv ====
// Function
// - Writing the transmit pointer starts a list walk that fills the transmit FIFO.
// - Writing the receive pointer starts a list walk draining received words to memory.
// - Descriptor is buffer address, byte length, next pointer; walk stops at end-of-chain.
// - Pointer bits 31-2 address, bit 1 direction, bit 0 end-of-chain.
// - Descriptor words are aligned long words fetched at incrementing physical addresses.
// - Writing zero to a pointer port aborts that direction's transfer.
// - Reading the transmit pointer offset returns the transmit FIFO word count.
// - Reading the receive pointer offset returns the receive count, pipeline included.
// - The single-word port writes the transmit FIFO and reads the receive path.
// - Pulsed almost-empty fires when transmit count falls below its threshold; urgent too.
// - Pulsed almost-full fires when combined receive count rises above its threshold.
// - Level almost-empty holds while transmit count is below its own threshold.
// - Level almost-full holds while combined receive count exceeds its own threshold.
// - Only the low threshold bits spanning the FIFO depth are compared.
// - Bus abort or a wrong fetched direction latches an error; raising that direction's error clear input clears it.
// - Each engine reports idle when not walking; software waits for idle.
`timescale 1ns/10ps
`include "sg_dma_params.svh"
module sg_dma_fifo_channel (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_address,
  input  wire logic [31:0] reg_write_data,
  output logic      [31:0] reg_read_data,
  output logic             reg_read_valid,
  output logic             mem_request,
  output logic             mem_write,
  output logic      [31:0] mem_address,
  output logic      [31:0] mem_write_data,
  input  wire logic        mem_ack,
  input  wire logic        mem_abort,
  input  wire logic [31:0] mem_read_data,
  output logic             tx_user_valid,
  output logic      [31:0] tx_user_data,
  input  wire logic        tx_user_ready,
  input  wire logic        rx_user_valid,
  input  wire logic [31:0] rx_user_data,
  output logic             rx_user_ready,
  output logic             tx_almost_empty_pulse,
  output logic             rx_almost_full_pulse,
  output logic             tx_almost_empty_level,
  output logic             rx_almost_full_level,
  output logic             tx_urgent,
  output logic             rx_urgent,
  input  wire logic        tx_error_clear,
  input  wire logic        rx_error_clear,
  output logic             tx_transfer_error_flag,
  output logic             rx_transfer_error_flag,
  output logic             tx_engine_idle_flag,
  output logic             rx_engine_idle_flag
);
  localparam int CNT = `SG_COUNT_WIDTH;

  fifo_stream_if #(.WIDTH(32)) tx_fill ();
  fifo_stream_if #(.WIDTH(32)) tx_drain ();
  fifo_stream_if #(.WIDTH(32)) rx_fill ();
  fifo_stream_if #(.WIDTH(32)) rx_mid ();
  fifo_stream_if #(.WIDTH(32)) rx_out ();

  logic [CNT-1:0]               tx_count;
  logic [CNT-1:0]               rx_fifo_count;
  logic [2:0]                   rx_pipe_count;
  logic [CNT-1:0]               rx_total;
  logic [`SG_THR_WIDTH-1:0]     tx_pulse_thr_q;
  logic [`SG_THR_WIDTH-1:0]     rx_pulse_thr_q;
  logic [`SG_THR_WIDTH-1:0]     tx_level_thr_q;
  logic [`SG_THR_WIDTH-1:0]     rx_level_thr_q;
  logic                         tx_below_pulse;
  logic                         rx_above_pulse;
  logic                         tx_below_level;
  logic                         rx_above_level;
  logic                         fifo_port_write;
  logic                         fifo_port_read;
  logic                         tx_data_pending;
  logic                         tx_dma_push;
  logic                         rx_dma_take;
  logic                         owner_q;
  logic                         pick;
  logic [1:0]                   ptr_write;
  logic [1:0]                   cancel;
  logic [1:0]                   pending;
  logic [1:0]                   want;
  logic [1:0]                   ack;
  logic [1:0]                   fault;
  logic [1:0]                   dir_bad;
  logic [1:0]                   data_ok;
  logic [1:0]                   error_clear;
  logic [1:0]                   err_q;
  logic [1:0]                   idle_q;
  sg_dma_pkg::engine_state_type state_q [2];
  sg_dma_pkg::word_type         desc_q [2];
  sg_dma_pkg::word_type         buf_q [2];
  sg_dma_pkg::word_type         len_q [2];
  sg_dma_pkg::word_type         next_q [2];
  sg_dma_pkg::word_type         req_addr [2];

  stream_fifo #(.WIDTH(32), .DEPTH(`SG_TX_FIFO_DEPTH)) tx_fifo (
    .clock  (clock),
    .reset  (reset),
    .enable (enable),
    .fill   (tx_fill),
    .drain  (tx_drain),
    .count  (tx_count)
  );

  stream_fifo #(.WIDTH(32), .DEPTH(`SG_RX_FIFO_DEPTH)) rx_fifo (
    .clock  (clock),
    .reset  (reset),
    .enable (enable),
    .fill   (rx_fill),
    .drain  (rx_mid),
    .count  (rx_fifo_count)
  );

  stream_fifo #(.WIDTH(32), .DEPTH(`SG_RX_PIPE_DEPTH)) rx_pipe (
    .clock  (clock),
    .reset  (reset),
    .enable (enable),
    .fill   (rx_mid),
    .drain  (rx_out),
    .count  (rx_pipe_count)
  );

  assign rx_total    = rx_fifo_count + {{(CNT - 3){1'b0}}, rx_pipe_count};
  assign ptr_write[0] = reg_write && (reg_address == `SG_OFF_TX_POINTER);
  assign ptr_write[1] = reg_write && (reg_address == `SG_OFF_RX_POINTER);
  assign cancel       = ptr_write & {2{reg_write_data == `SG_WORD_RESET}};
  assign fifo_port_write = reg_write && (reg_address == `SG_OFF_FIFO_PORT);
  assign fifo_port_read  = reg_read && (reg_address == `SG_OFF_FIFO_PORT);
  assign error_clear     = {rx_error_clear, tx_error_clear};

  // Register pushes are held off while a transmit data fetch is in flight, so the slot
  // that the fetch checked for stays free until its word returns.
  assign tx_data_pending = pending[0] && (state_q[0] == sg_dma_pkg::eng_move);
  assign tx_dma_push     = ack[0] && (state_q[0] == sg_dma_pkg::eng_move);
  assign tx_fill.valid   = tx_dma_push || (fifo_port_write && !tx_data_pending);
  assign tx_fill.data    = tx_dma_push ? mem_read_data : reg_write_data;
  assign data_ok[0]      = tx_fill.ready && !fifo_port_write;
  assign data_ok[1]      = rx_out.valid;

  assign pick        = !want[0];
  assign rx_dma_take = !mem_request && pick && want[1] && (state_q[1] == sg_dma_pkg::eng_move);
  assign rx_out.ready = rx_dma_take || fifo_port_read;
  assign rx_fill.valid = rx_user_valid && rx_user_ready;
  assign rx_fill.data  = rx_user_data;
  assign tx_drain.ready = !tx_user_valid || tx_user_ready;

  assign tx_transfer_error_flag = err_q[0];
  assign rx_transfer_error_flag = err_q[1];
  assign tx_engine_idle_flag    = idle_q[0];
  assign rx_engine_idle_flag    = idle_q[1];

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_pulse_thr_q <= `SG_THR_RESET;
      rx_pulse_thr_q <= `SG_THR_RESET;
      tx_level_thr_q <= `SG_THR_RESET;
      rx_level_thr_q <= `SG_THR_RESET;
    end else if (enable && reg_write) begin
      case (reg_address)
        `SG_OFF_TX_PULSE_THR: tx_pulse_thr_q <= reg_write_data[`SG_THR_WIDTH-1:0];
        `SG_OFF_RX_PULSE_THR: rx_pulse_thr_q <= reg_write_data[`SG_THR_WIDTH-1:0];
        `SG_OFF_TX_LEVEL_THR: tx_level_thr_q <= reg_write_data[`SG_THR_WIDTH-1:0];
        `SG_OFF_RX_LEVEL_THR: rx_level_thr_q <= reg_write_data[`SG_THR_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_valid <= 1'b0;
      reg_read_data  <= `SG_WORD_RESET;
    end else if (enable) begin
      reg_read_valid <= reg_read;
      if (reg_read) begin
        case (reg_address)
          `SG_OFF_TX_POINTER:   reg_read_data <= 32'(tx_count);
          `SG_OFF_RX_POINTER:   reg_read_data <= 32'(rx_total);
          `SG_OFF_FIFO_PORT:    reg_read_data <= rx_out.valid ? rx_out.data : `SG_WORD_RESET;
          `SG_OFF_TX_PULSE_THR: reg_read_data <= 32'(tx_pulse_thr_q);
          `SG_OFF_RX_PULSE_THR: reg_read_data <= 32'(rx_pulse_thr_q);
          `SG_OFF_TX_LEVEL_THR: reg_read_data <= 32'(tx_level_thr_q);
          `SG_OFF_RX_LEVEL_THR: reg_read_data <= 32'(rx_level_thr_q);
          default:              reg_read_data <= `SG_WORD_RESET;
        endcase
      end
    end
  end

  AST_COUNT_READ: assert property (@(posedge clock) disable iff (reset)
    (enable && reg_read && reg_address == `SG_OFF_TX_POINTER)
    |=> reg_read_valid && reg_read_data == 32'($past(tx_count)))
    else $error("transmit count read returned a wrong value");

  assign tx_below_pulse = tx_count < tx_pulse_thr_q[CNT-1:0];
  assign rx_above_pulse = rx_total > rx_pulse_thr_q[CNT-1:0];
  assign tx_below_level = tx_count < tx_level_thr_q[CNT-1:0];
  assign rx_above_level = rx_total > rx_level_thr_q[CNT-1:0];

  // The urgent outputs hold the previous comparison, so each pulse marks a rising edge.
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_urgent             <= 1'b0;
      rx_urgent             <= 1'b0;
      tx_almost_empty_pulse <= 1'b0;
      rx_almost_full_pulse  <= 1'b0;
      tx_almost_empty_level <= 1'b0;
      rx_almost_full_level  <= 1'b0;
    end else if (enable) begin
      tx_urgent             <= tx_below_pulse;
      rx_urgent             <= rx_above_pulse;
      tx_almost_empty_pulse <= tx_below_pulse && !tx_urgent;
      rx_almost_full_pulse  <= rx_above_pulse && !rx_urgent;
      tx_almost_empty_level <= tx_below_level;
      rx_almost_full_level  <= rx_above_level;
    end
  end

  AST_TX_PULSE: assert property (@(posedge clock) disable iff (reset)
    (enable && tx_below_pulse && !tx_urgent) |=> tx_almost_empty_pulse && tx_urgent)
    else $error("transmit almost-empty pulse missed");

  AST_RX_LEVEL: assert property (@(posedge clock) disable iff (reset)
    enable |=> rx_almost_full_level == ($past(rx_total) > $past(rx_level_thr_q[CNT-1:0])))
    else $error("receive almost-full level wrong");

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_user_valid <= 1'b0;
      tx_user_data  <= `SG_WORD_RESET;
      rx_user_ready <= 1'b0;
    end else if (enable) begin
      if (tx_drain.ready) begin
        tx_user_valid <= tx_drain.valid;
        tx_user_data  <= tx_drain.data;
      end
      rx_user_ready <= rx_fifo_count < `SG_RX_FILL_LIMIT;
    end
  end

  // A cancelled engine withdraws its outstanding request; the memory side must accept that.
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_request    <= 1'b0;
      mem_write      <= 1'b0;
      mem_address    <= `SG_WORD_RESET;
      mem_write_data <= `SG_WORD_RESET;
      owner_q        <= 1'b0;
    end else if (enable) begin
      if (mem_request) begin
        if (mem_ack || mem_abort || cancel[owner_q]) begin
          mem_request <= 1'b0;
        end
      end else if (|want) begin
        mem_request    <= 1'b1;
        owner_q        <= pick;
        mem_address    <= req_addr[pick];
        mem_write      <= pick && (state_q[1] == sg_dma_pkg::eng_move);
        mem_write_data <= rx_out.data;
      end
    end
  end

  AST_TX_STALL: assert property (@(posedge clock) disable iff (reset)
    tx_dma_push |-> tx_fill.ready)
    else $error("transmit word returned with the FIFO full");

  AST_RX_STORE: assert property (@(posedge clock) disable iff (reset)
    (enable && rx_dma_take) |-> rx_out.valid ##1 (mem_request && mem_write))
    else $error("receive store issued without a word");

  for (genvar i = 0; i < 2; i++) begin : engine
    logic                 step_now;
    sg_dma_pkg::word_type step_ptr;

    assign pending[i] = mem_request && (owner_q == 1'(i));
    assign ack[i]     = pending[i] && mem_ack;
    assign fault[i]   = pending[i] && mem_abort && !mem_ack;
    assign dir_bad[i] = ack[i] && (state_q[i] == sg_dma_pkg::eng_fetch_next)
                        && (mem_read_data[`SG_PTR_DIR_BIT] != 1'(i));
    assign want[i] = !pending[i] && !cancel[i] && !ptr_write[i]
                     && ((state_q[i] == sg_dma_pkg::eng_fetch_buffer)
                     || (state_q[i] == sg_dma_pkg::eng_fetch_length)
                     || (state_q[i] == sg_dma_pkg::eng_fetch_next)
                     || ((state_q[i] == sg_dma_pkg::eng_move) && data_ok[i]));

    always_comb begin
      case (state_q[i])
        sg_dma_pkg::eng_fetch_length: req_addr[i] = desc_q[i] + `SG_LENGTH_OFFSET;
        sg_dma_pkg::eng_fetch_next:   req_addr[i] = desc_q[i] + `SG_NEXT_OFFSET;
        sg_dma_pkg::eng_move:         req_addr[i] = buf_q[i];
        default:                      req_addr[i] = desc_q[i];
      endcase
    end

    // A segment ends after its last word, or at once when its length is under a word.
    assign step_ptr = (state_q[i] == sg_dma_pkg::eng_fetch_next) ? mem_read_data : next_q[i];
    assign step_now = ack[i] && !dir_bad[i]
                      && (((state_q[i] == sg_dma_pkg::eng_fetch_next)
                      && (len_q[i] < `SG_WORD_BYTES))
                      || ((state_q[i] == sg_dma_pkg::eng_move)
                      && (len_q[i] <= `SG_WORD_BYTES)));

    always_ff @(posedge clock) begin
      if (reset) begin
        state_q[i] <= sg_dma_pkg::eng_idle;
        desc_q[i]  <= `SG_WORD_RESET;
        buf_q[i]   <= `SG_WORD_RESET;
        len_q[i]   <= `SG_WORD_RESET;
        next_q[i]  <= `SG_WORD_RESET;
      end else if (enable) begin
        if (ptr_write[i]) begin
          if (cancel[i]) begin
            state_q[i] <= sg_dma_pkg::eng_idle;
          end else if (state_q[i] == sg_dma_pkg::eng_idle) begin
            desc_q[i]  <= {reg_write_data[`SG_PTR_ADDR_MSB:`SG_PTR_ADDR_LSB], 2'b00};
            state_q[i] <= sg_dma_pkg::eng_fetch_buffer;
          end
        end else if (fault[i] || dir_bad[i]) begin
          state_q[i] <= sg_dma_pkg::eng_idle;
        end else if (step_now) begin
          if (step_ptr[`SG_PTR_EOC_BIT]) begin
            state_q[i] <= sg_dma_pkg::eng_idle;
          end else begin
            desc_q[i]  <= {step_ptr[`SG_PTR_ADDR_MSB:`SG_PTR_ADDR_LSB], 2'b00};
            state_q[i] <= sg_dma_pkg::eng_fetch_buffer;
          end
          if (state_q[i] == sg_dma_pkg::eng_fetch_next) begin
            next_q[i] <= mem_read_data;
          end
        end else if (ack[i]) begin
          case (state_q[i])
            sg_dma_pkg::eng_fetch_buffer: begin
              buf_q[i]   <= mem_read_data;
              state_q[i] <= sg_dma_pkg::eng_fetch_length;
            end
            sg_dma_pkg::eng_fetch_length: begin
              len_q[i]   <= mem_read_data;
              state_q[i] <= sg_dma_pkg::eng_fetch_next;
            end
            sg_dma_pkg::eng_fetch_next: begin
              next_q[i]  <= mem_read_data;
              state_q[i] <= sg_dma_pkg::eng_move;
            end
            sg_dma_pkg::eng_move: begin
              buf_q[i] <= buf_q[i] + `SG_WORD_BYTES;
              len_q[i] <= len_q[i] - `SG_WORD_BYTES;
            end
            default: state_q[i] <= sg_dma_pkg::eng_idle;
          endcase
        end
      end
    end

    // A new fault wins over a clear in the same cycle.
    always_ff @(posedge clock) begin
      if (reset) begin
        err_q[i]  <= 1'b0;
        idle_q[i] <= 1'b1;
      end else if (enable) begin
        if (fault[i] || dir_bad[i]) begin
          err_q[i] <= 1'b1;
        end else if (error_clear[i]) begin
          err_q[i] <= 1'b0;
        end
        idle_q[i] <= (state_q[i] == sg_dma_pkg::eng_idle);
      end
    end

    AST_START: assert property (@(posedge clock) disable iff (reset)
      (enable && ptr_write[i] && !cancel[i] && state_q[i] == sg_dma_pkg::eng_idle)
      |=> state_q[i] == sg_dma_pkg::eng_fetch_buffer
          && desc_q[i] == {$past(reg_write_data[31:2]), 2'b00})
      else $error("pointer write did not start the engine");

    AST_ABORT: assert property (@(posedge clock) disable iff (reset)
      (enable && cancel[i]) |=> state_q[i] == sg_dma_pkg::eng_idle ##1 idle_q[i])
      else $error("zero pointer write did not abort");

    AST_LENGTH_ADDR: assert property (@(posedge clock) disable iff (reset)
      (pending[i] && state_q[i] == sg_dma_pkg::eng_fetch_length)
      |-> mem_address == desc_q[i] + `SG_LENGTH_OFFSET && !mem_write)
      else $error("length word fetched from a wrong address");

    AST_ORDER: assert property (@(posedge clock) disable iff (reset)
      (enable && ack[i] && !ptr_write[i] && state_q[i] == sg_dma_pkg::eng_fetch_buffer)
      |=> state_q[i] == sg_dma_pkg::eng_fetch_length && buf_q[i] == $past(mem_read_data))
      else $error("buffer address not followed by length fetch");

    AST_DIR_ERROR: assert property (@(posedge clock) disable iff (reset)
      (enable && dir_bad[i] && !ptr_write[i])
      |=> err_q[i] && state_q[i] == sg_dma_pkg::eng_idle)
      else $error("wrong direction flag not flagged");
  end
endmodule

// ==== design/sg_dma_params.svh ====
`ifndef SG_DMA_PARAMS_SVH
`define SG_DMA_PARAMS_SVH

`define SG_OFF_TX_POINTER   8'h08
`define SG_OFF_RX_POINTER   8'h0c
`define SG_OFF_FIFO_PORT    8'h10
`define SG_OFF_TX_PULSE_THR 8'h14
`define SG_OFF_RX_PULSE_THR 8'h18
`define SG_OFF_TX_LEVEL_THR 8'h28
`define SG_OFF_RX_LEVEL_THR 8'h40

`define SG_PTR_EOC_BIT  0
`define SG_PTR_DIR_BIT  1
`define SG_PTR_ADDR_MSB 31
`define SG_PTR_ADDR_LSB 2

`define SG_TX_FIFO_DEPTH 8192
`define SG_RX_FIFO_DEPTH 8192
`define SG_RX_PIPE_DEPTH 4
`define SG_COUNT_WIDTH   14
`define SG_THR_WIDTH     16
`define SG_RX_FILL_LIMIT 14'h1ffe

`define SG_WORD_BYTES    32'h0000_0004
`define SG_LENGTH_OFFSET 32'h0000_0004
`define SG_NEXT_OFFSET   32'h0000_0008
`define SG_THR_RESET     16'h0000
`define SG_WORD_RESET    32'h0000_0000

`endif

// ==== design/sg_dma_pkg.sv ====
package sg_dma_pkg;

  typedef enum {
    eng_idle,
    eng_fetch_buffer,
    eng_fetch_length,
    eng_fetch_next,
    eng_move
  } engine_state_type;

  typedef logic [31:0] word_type;

endpackage

// ==== design/fifo_stream_if.sv ====
`timescale 1ns/10ps
interface fifo_stream_if #(
  parameter int WIDTH = 32
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== design/stream_fifo.sv ====
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      enable,
  fifo_stream_if.sink                    fill,
  fifo_stream_if.source                  drain,
  output logic [$clog2(DEPTH+1)-1:0]     count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW-1:0]    write_ptr_q;
  logic [AW-1:0]    read_ptr_q;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] advance(input logic [AW-1:0] ptr);
    advance = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
  endfunction

  assign fill.ready  = (count != CW'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = store_q[read_ptr_q];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clock) begin
    if (enable && push) begin
      store_q[write_ptr_q] <= fill.data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      write_ptr_q <= '0;
      read_ptr_q  <= '0;
      count       <= '0;
    end else if (enable) begin
      if (push) begin
        write_ptr_q <= advance(write_ptr_q);
      end
      if (pop) begin
        read_ptr_q <= advance(read_ptr_q);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== tb/host_memory_model.sv ====
`timescale 1ns/10ps
module host_memory_model (
  input  wire logic        clock,
  input  wire logic        mem_request,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_address,
  input  wire logic [31:0] mem_write_data,
  input  wire logic        abort_next,
  output logic             mem_ack,
  output logic             mem_abort,
  output logic      [31:0] mem_read_data
);
  logic [31:0] mem [0:255];
  integer      seed = 5;
  initial {mem_ack, mem_abort, mem_read_data} = '0;
  // Answers after a random wait; read data toggles in every cycle except an acknowledge.
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_abort <= 1'b0;
    mem_read_data <= ~mem_read_data;
    if (mem_request && !mem_ack && !mem_abort && $random(seed) % 2) begin
      if (abort_next) begin
        mem_abort <= 1'b1;
      end else begin
        mem_ack <= 1'b1;
        mem_read_data <= mem[mem_address[9:2]];
        if (mem_write) begin
          mem[mem_address[9:2]] <= mem_write_data;
        end
      end
    end
  end
endmodule

// ==== tb/sg_dma_fifo_channel_bench.sv ====
`timescale 1ns/10ps
module sg_dma_fifo_channel_bench;
  logic        clock = 0, reset = 1, reg_write = 0, reg_read = 0, tx_user_ready = 0;
  logic        rx_user_valid = 0, tx_error_clear = 0, rx_error_clear = 0, abort_next = 0;
  logic        enable = 1;
  logic [7:0]  reg_address = '0;
  logic [31:0] reg_write_data = '0, rx_user_data = '0, rdata, d, w [0:3];
  logic [31:0] reg_read_data, mem_address, mem_write_data, mem_read_data, tx_user_data;
  logic        reg_read_valid, mem_request, mem_write, mem_ack, mem_abort, tx_user_valid;
  logic        rx_user_ready, tx_almost_empty_pulse, rx_almost_full_pulse, tx_urgent, rx_urgent;
  logic        tx_almost_empty_level, rx_almost_full_level, tx_transfer_error_flag;
  logic        rx_transfer_error_flag, tx_engine_idle_flag, rx_engine_idle_flag;
  integer      n_mismatch = 0, checks = 0, n_txp = 0, n_rxp = 0, seed = 32'h7881ed06;
  always #12.5 clock = ~clock;
  sg_dma_fifo_channel u_dut (.clock, .reset, .enable, .reg_write, .reg_read,
    .reg_address, .reg_write_data, .reg_read_data, .reg_read_valid, .mem_request, .mem_write,
    .mem_address, .mem_write_data, .mem_ack, .mem_abort, .mem_read_data, .tx_user_valid,
    .tx_user_data, .tx_user_ready, .rx_user_valid, .rx_user_data, .rx_user_ready,
    .tx_almost_empty_pulse, .rx_almost_full_pulse, .tx_almost_empty_level,
    .rx_almost_full_level, .tx_urgent, .rx_urgent, .tx_error_clear, .rx_error_clear,
    .tx_transfer_error_flag, .rx_transfer_error_flag, .tx_engine_idle_flag,
    .rx_engine_idle_flag);
  host_memory_model u_mem (.clock, .mem_request, .mem_write, .mem_address, .mem_write_data,
    .abort_next, .mem_ack, .mem_abort, .mem_read_data);
  always @(posedge clock) begin
    if (tx_almost_empty_pulse === 1'b1) n_txp++;
    if (rx_almost_full_pulse === 1'b1) n_rxp++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clock);
    {reg_write, reg_address, reg_write_data} = {1'b1, a, v};
    @(negedge clock);
    reg_write = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    {reg_read, reg_address} = {1'b1, a};
    @(negedge clock);
    reg_read = 0;
    rdata = reg_read_data;
    chk("read valid", 1, reg_read_valid);
  endtask
  task automatic push(input logic [31:0] v);
    @(negedge clock);
    {rx_user_valid, rx_user_data} = {1'b1, v};
    @(negedge clock);
    rx_user_valid = 0;
    chk("rx ready", 1, rx_user_ready);
  endtask
  task automatic pull(input int n);
    int k;
    int t;
    k = 0;
    tx_user_ready = 1;
    // The word shown now is the one taken at the next rising edge.
    for (t = 0; k < n && t < 300; t++) begin
      if (tx_user_valid === 1'b1) begin
        chk("tx word", w[k], tx_user_data);
        k++;
      end
      @(negedge clock);
    end
    @(negedge clock);
    tx_user_ready = 0;
    chk("tx word count", n, k);
  endtask
  task automatic desc(input int a, input logic [31:0] b, input logic [31:0] l,
                      input logic [31:0] n);
    u_mem.mem[a/4] = b;
    u_mem.mem[a/4+1] = l;
    u_mem.mem[a/4+2] = n;
  endtask
  task automatic wait_idle;
    int i;
    repeat (4) @(negedge clock);
    for (i = 0; i < 3000 && !(tx_engine_idle_flag === 1 && rx_engine_idle_flag === 1); i++)
      @(negedge clock);
    if (i == 3000) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic finish_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  logic [7:0] thr [4] = '{8'h14, 8'h18, 8'h28, 8'h40};
  initial begin
    repeat (20) @(negedge clock);
    reset = 0;
    chk("tx idle", 1, tx_engine_idle_flag);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(thr[i], d);
      rd(thr[i]);
      chk("threshold", {16'h0000, d[15:0]}, {16'h0000, rdata[15:0]});
    end
    wr(8'h14, 32'h0000_c003);
    wr(8'h28, 32'h0000_4003);
    wr(8'h18, 32'h0000_8001);
    wr(8'h40, 32'h0000_c002);
    for (int i = 0; i < 4; i++) w[i] = $random(seed);
    for (int i = 0; i < 4; i++) wr(8'h10, w[i]);
    rd(8'h08);
    // The first word already sits in the output register, outside the FIFO.
    chk("tx count", 3, rdata);
    chk("tx level", 0, tx_almost_empty_level);
    // With the clock enable low nothing may move, though the user side is ready.
    enable = 0;
    tx_user_ready = 1;
    repeat (3) @(negedge clock);
    chk("frozen word", w[0], tx_user_data);
    enable = 1;
    n_txp = 0;
    pull(4);
    rd(8'h08);
    chk("tx level", 1, tx_almost_empty_level);
    chk("tx pulses", 1, n_txp);
    chk("tx urgent", 1, tx_urgent);
    $display("test threshold and port done");
    for (int i = 0; i < 3; i++) push(w[i]);
    rd(8'h0c);
    chk("rx count", 3, rdata);
    chk("rx level", 1, rx_almost_full_level);
    chk("rx pulses", 1, n_rxp);
    chk("rx urgent", 1, rx_urgent);
    rd(8'h10);
    chk("rx word", w[0], rdata);
    desc(32'h40, 32'h300, 32'h8, 32'h3);
    wr(8'h0c, 32'h42);
    wait_idle();
    chk("rx store", w[1], u_mem.mem[192]);
    chk("rx store", w[2], u_mem.mem[193]);
    $display("test rx dma done");
    desc(32'h10, 32'h200, 32'h8, 32'h20);
    desc(32'h20, 32'h280, 32'h4, 32'h1);
    u_mem.mem[128] = w[0];
    u_mem.mem[129] = w[1];
    u_mem.mem[160] = w[2];
    wr(8'h08, 32'h10);
    wait_idle();
    pull(3);
    $display("test tx dma done");
    desc(32'h30, 32'h200, 32'h0, 32'h3);
    wr(8'h08, 32'h30);
    wait_idle();
    chk("tx error", 1, tx_transfer_error_flag);
    @(negedge clock) tx_error_clear = 1;
    @(negedge clock) tx_error_clear = 0;
    chk("tx error", 0, tx_transfer_error_flag);
    abort_next = 1;
    wr(8'h0c, 32'h42);
    wait_idle();
    abort_next = 0;
    chk("rx error", 1, rx_transfer_error_flag);
    $display("test errors done");
    desc(32'h50, 32'h0, 32'h400, 32'h1);
    wr(8'h08, 32'h50);
    repeat (6) @(negedge clock);
    chk("tx idle", 0, tx_engine_idle_flag);
    wr(8'h08, 32'h0);
    repeat (4) @(negedge clock);
    chk("tx idle", 1, tx_engine_idle_flag);
    rd(8'h08);
    chk("aborted count", 1, {31'h0, rdata < 256});
    $display("test abort done");
    finish_test();
  end
endmodule
